// ===== gpio_opt_pkg.sv
/*
 Package for the pad option latch and pin role select block.
 Holds register offsets, field positions, reset values and the pin carrier struct.
 Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package gpio_opt_pkg;
   localparam int PIN_COUNT = 10;
   localparam int ADDR_W = 5;

   // Register byte offsets on the register bus.
   localparam logic [ADDR_W-1:0] PORT_CTRL_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] PORT_SET_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] CRYSTAL_CTRL_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] PORT_LOW_VALUE_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] PORT_LOW_CFG_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] PORT_HIGH_VALUE_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] PORT_HIGH_CFG_OFS = 5'h18;
   localparam logic [ADDR_W-1:0] READBACK_OFS = 5'h1C;

   // Field positions of the pad option control register.
   localparam int STROBE_BIT = 7;
   localparam int MATRIX_BIT = 6;
   localparam int ROFF_BIT = 5;
   localparam int LED_LVL_LSB = 0;
   localparam int LED_LVL_MSB = 1;

   // Field positions of the special set register.
   localparam int REFEN_BIT = 0;
   localparam int CLKEN_BIT = 1;
   localparam int CLKOUT_LSB = 2;
   localparam int CLKOUT_MSB = 3;

   // Field positions of the crystal control and readback registers.
   localparam int CRYSTAL_ENA_BIT = 0;
   localparam int LED_ACTUAL_BIT = 0;

   // Pins with special roles.
   localparam int PIN_CRYSTAL = 0;
   localparam int PIN_REF = 3;
   localparam int PIN_DBG_DATA = 4;
   localparam int PIN_LED = 5;
   localparam int PIN_CLKOUT2 = 6;

   // Reset values.
   localparam logic [7:0] PORT_CTRL_RST = 8'h00;
   localparam logic [7:0] PORT_SET_RST = 8'h00;
   localparam logic [7:0] CRYSTAL_CTRL_RST = 8'h00;
   localparam logic [7:0] PORT_LOW_VALUE_RST = 8'hDF;
   localparam logic [7:0] PORT_LOW_CFG_RST = 8'h00;
   localparam logic [1:0] PORT_HIGH_VALUE_RST = 2'h3;
   localparam logic [1:0] PORT_HIGH_CFG_RST = 2'h0;
   localparam logic [1:0] OPTION_STORE_RST = 2'h0;

   // Pins affected by the pad options.
   localparam logic [9:0] MATRIX_PINS = 10'h00E;
   localparam logic [9:0] ROFF_PINS = 10'h006;

   // Everything the block drives toward the pads, one bit per pin.
   typedef struct packed {
      logic [PIN_COUNT-1:0] out;
      logic [PIN_COUNT-1:0] oe;
      logic [PIN_COUNT-1:0] pullup_en;
      logic [PIN_COUNT-1:0] pulldown_en;
   } pad_drive_t;

   // Option store contents: matrix wake and pull-up removal.
   typedef struct packed {
      logic matrix;
      logic roff;
   } option_t;
endpackage

// ===== gpio_option_latch_and_role_select.sv
/*
 Pad-side logic for the general-purpose pins: the retained two-bit option store,
 the port registers, and the fixed-priority selection of each pin's special role.
 Assumes a synchronous Avalon-MM master, pad inputs synchronous to clk_sys, and a
 separate pad power-on reset (rst_pad) that stays inactive through core shutdown.
*/
// Summary of operation
// - Two-bit option store survives core shutdown.
// - Strobe 0-1-0 loads matrix and pull-up-removal bits.
// - Option strobe is control bit 7.
// - Matrix request bit 6, pull-up removal bit 5.
// - Option bit reads return stored option values.
// - Lower order role overrides higher order controls.
// - Pin 0: programming supply, crystal, then input.
// - Pin 3 carries reference clock when enabled.
// - Pin 4: debug data, clock output, then port.
// - Pin 5 debug clock unless LED driver on.
// - LED has two-bit level, switched by bit 5.
// - LED on disables pin 5 pull-down transistor.
// - Pin 5 output stage fixed open-drain.
// - Pin 5 plain open-drain only during debug.
// - Actual LED drive state in readback status.
// - Matrix option: pins 3..1 pull-ups off, pull-downs on.
// - Removal option disconnects pull-ups on affected pins.
`timescale 1ns/10ps
`default_nettype none
module gpio_option_latch_and_role_select (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rst_pad,
   input wire logic [gpio_opt_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [gpio_opt_pkg::PIN_COUNT-1:0] gpio_in,
   output gpio_opt_pkg::pad_drive_t pad_drive,
   input wire logic prog_supply_active,
   input wire logic debug_transaction,
   input wire logic debug_session,
   input wire logic debug_data_out,
   input wire logic debug_data_oe,
   output logic debug_data_in,
   output logic debug_clock_in,
   input wire logic clock_output_src,
   output logic ref_clock_out,
   output logic crystal_oscillator_input,
   output logic [1:0] led_current_level,
   output logic led_drive_actual
);
   import gpio_opt_pkg::*;

   logic [7:0] port_ctrl_reg;
   logic [7:0] port_set_reg;
   logic [7:0] crystal_osc_control_reg;
   logic [7:0] port_low_value_reg;
   logic [7:0] port_low_drive_config_reg;
   logic [1:0] port_high_value_reg;
   logic [1:0] port_high_drive_config_reg;
   option_t option_store_reg;
   logic ack_reg;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic wr_take;
   logic [9:0] port_value;
   logic [9:0] port_push_pull;
   logic [9:0] gen_out;
   logic [9:0] gen_oe;
   logic [9:0] gen_pullup;
   logic ref_clock_pin_enable;
   logic clock_output_enable;
   logic [1:0] clock_output_pin_select;
   logic crystal_osc_enable;
   logic led_intended;

   // Every access takes one wait cycle, so decode and read data come from flops.
   assign waitrequest = (read | write) & ~ack_reg;
   assign wr_take = write & ack_reg;
   assign readdata = readdata_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   // Field aliases for the role logic.
   assign ref_clock_pin_enable = port_set_reg[REFEN_BIT];
   assign clock_output_enable = port_set_reg[CLKEN_BIT];
   assign clock_output_pin_select = port_set_reg[CLKOUT_MSB:CLKOUT_LSB];
   assign crystal_osc_enable = crystal_osc_control_reg[CRYSTAL_ENA_BIT];
   assign led_current_level = port_ctrl_reg[LED_LVL_MSB:LED_LVL_LSB];
   assign port_value = {port_high_value_reg, port_low_value_reg};
   assign port_push_pull = {port_high_drive_config_reg, port_low_drive_config_reg};

   // requests at bits 6 and 5
   // The request bits are kept here and only reach the pads through the store.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         port_ctrl_reg <= PORT_CTRL_RST;
      end else if (wr_take && address == PORT_CTRL_OFS) begin
         port_ctrl_reg <= writedata[7:0];
      end
   end

   // Special role enables.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         port_set_reg <= PORT_SET_RST;
      end else if (wr_take && address == PORT_SET_OFS) begin
         port_set_reg <= writedata[7:0];
      end
   end

   // Crystal oscillator control.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crystal_osc_control_reg <= CRYSTAL_CTRL_RST;
      end else if (wr_take && address == CRYSTAL_CTRL_OFS) begin
         crystal_osc_control_reg <= writedata[7:0];
      end
   end

   // Port values and drive modes; the upper port only uses its two low bits.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         port_low_value_reg <= PORT_LOW_VALUE_RST;
         port_low_drive_config_reg <= PORT_LOW_CFG_RST;
         port_high_value_reg <= PORT_HIGH_VALUE_RST;
         port_high_drive_config_reg <= PORT_HIGH_CFG_RST;
      end else if (wr_take) begin
         if (address == PORT_LOW_VALUE_OFS) begin
            port_low_value_reg <= writedata[7:0];
         end
         if (address == PORT_LOW_CFG_OFS) begin
            port_low_drive_config_reg <= writedata[7:0];
         end
         if (address == PORT_HIGH_VALUE_OFS) begin
            port_high_value_reg <= writedata[1:0];
         end
         if (address == PORT_HIGH_CFG_OFS) begin
            port_high_drive_config_reg <= writedata[1:0];
         end
      end
   end

   // retained option store
   // The store sits on the pad power-on reset only, so a core reset or shutdown
   // leaves the user's options in force.
   // reloaded at every clk_sys edge while strobe high
   always_ff @(posedge clk_sys or posedge rst_pad) begin
      if (rst_pad) begin
         option_store_reg <= OPTION_STORE_RST;
      end else if (port_ctrl_reg[STROBE_BIT]) begin
         option_store_reg.matrix <= port_ctrl_reg[MATRIX_BIT];
         option_store_reg.roff <= port_ctrl_reg[ROFF_BIT];
      end
   end

   // LED level and switch
   // Software sees its intent; the adapter may still force the driver off.
   assign led_intended = port_low_value_reg[PIN_LED] & (led_current_level != 2'h0);
   assign led_drive_actual = led_intended & ~debug_session;

   // Read mux, latched on the wait cycle so data stand at the completing edge.
   always_comb begin
      readdata_next = 32'h0000_0000;
      case (address)
         PORT_CTRL_OFS: begin
            readdata_next[7:0] = port_ctrl_reg;
            readdata_next[MATRIX_BIT] = option_store_reg.matrix;
            readdata_next[ROFF_BIT] = option_store_reg.roff;
         end
         PORT_SET_OFS: begin
            readdata_next[7:0] = port_set_reg;
         end
         CRYSTAL_CTRL_OFS: begin
            readdata_next[7:0] = crystal_osc_control_reg;
         end
         PORT_LOW_VALUE_OFS: begin
            readdata_next[7:0] = gpio_in[7:0];
            readdata_next[PIN_LED] = led_intended;
         end
         PORT_LOW_CFG_OFS: begin
            readdata_next[7:0] = port_low_drive_config_reg;
         end
         PORT_HIGH_VALUE_OFS: begin
            readdata_next[1:0] = gpio_in[9:8];
         end
         PORT_HIGH_CFG_OFS: begin
            readdata_next[1:0] = port_high_drive_config_reg;
         end
         READBACK_OFS: begin
            readdata_next[LED_ACTUAL_BIT] = led_drive_actual;
         end
         default: begin
            readdata_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (read && !ack_reg) begin
         readdata_reg <= readdata_next;
      end
   end

   // Plain port behaviour per pin: open-drain pulls low only, push-pull drives both
   // ways. Pull-ups sit on open-drain pins unless an option in the store removes them.
   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
         always_comb begin
            gen_out[i] = port_push_pull[i] & port_value[i];
            gen_oe[i] = port_push_pull[i] | ~port_value[i];
            gen_pullup[i] = ~port_push_pull[i]
               & ~(option_store_reg.matrix & MATRIX_PINS[i])
               & ~(option_store_reg.roff & ROFF_PINS[i]);
         end
      end
   endgenerate

   // fixed role priority
   // Each pin's special roles are resolved top down; a higher role masks the output
   // and enable controls of the roles below it.
   always_comb begin
      pad_drive.out = gen_out;
      pad_drive.oe = gen_oe;
      pad_drive.pullup_en = gen_pullup;
      pad_drive.pulldown_en = option_store_reg.matrix ? MATRIX_PINS : 10'h000;

      pad_drive.out[PIN_CRYSTAL] = 1'b0;
      pad_drive.oe[PIN_CRYSTAL] = 1'b0;
      if (prog_supply_active || crystal_osc_enable) begin
         pad_drive.pullup_en[PIN_CRYSTAL] = 1'b0;
      end

      if (ref_clock_pin_enable) begin
         pad_drive.out[PIN_REF] = 1'b0;
         pad_drive.oe[PIN_REF] = 1'b0;
      end

      if (debug_transaction) begin
         pad_drive.out[PIN_DBG_DATA] = debug_data_out;
         pad_drive.oe[PIN_DBG_DATA] = debug_data_oe;
      end else if (clock_output_enable && clock_output_pin_select[0]) begin
         pad_drive.out[PIN_DBG_DATA] = clock_output_src;
         pad_drive.oe[PIN_DBG_DATA] = 1'b1;
      end

      // Second clock output pin; the clock is only a role, so no flop sits on it.
      if (clock_output_enable && clock_output_pin_select[1]) begin
         pad_drive.out[PIN_CLKOUT2] = clock_output_src;
         pad_drive.oe[PIN_CLKOUT2] = 1'b1;
      end

      // debug clock unless LED
      // Outside a debug session the pin is the LED driver and never pulls low,
      // which keeps the debug clock line free whenever the LED is dark.
      pad_drive.out[PIN_LED] = 1'b0;
      pad_drive.oe[PIN_LED] = debug_session & ~port_low_value_reg[PIN_LED] & ~led_drive_actual;
      pad_drive.pullup_en[PIN_LED] = 1'b0;
   end

   // Role inputs handed back to the core.
   assign crystal_oscillator_input = ~prog_supply_active & crystal_osc_enable & gpio_in[PIN_CRYSTAL];
   assign ref_clock_out = ref_clock_pin_enable & gpio_in[PIN_REF];
   assign debug_data_in = gpio_in[PIN_DBG_DATA];
   assign debug_clock_in = ~led_drive_actual & gpio_in[PIN_LED];
endmodule
`default_nettype wire

// ===== gpio_opt_props.sv
/*
 Checker for the pad option and pin role block.
 Sees only the top-level ports and is bound to the design below.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_opt_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [gpio_opt_pkg::PIN_COUNT-1:0] gpio_in,
   input wire gpio_opt_pkg::pad_drive_t pad_drive,
   input wire logic prog_supply_active,
   input wire logic debug_transaction,
   input wire logic debug_session,
   input wire logic debug_data_oe,
   input wire logic debug_data_in,
   input wire logic debug_clock_in,
   input wire logic crystal_oscillator_input,
   input wire logic [1:0] led_current_level,
   input wire logic led_drive_actual
);
   import gpio_opt_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A request waits one cycle, so a stuck wait shows up at once.
   sequence req_wait_s;
      (read || write) && waitrequest;
   endsequence
   wait_one_a: assert property (req_wait_s |=> !waitrequest)
      else $error("bus wait not one cycle");
   upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   crystal_prog_a: assert property (prog_supply_active |-> !crystal_oscillator_input)
      else $error("crystal input active under programming supply");
   pin0_input_a: assert property (!pad_drive.oe[PIN_CRYSTAL])
      else $error("pin 0 driven");
   dbg_data_a: assert property (debug_transaction |-> pad_drive.oe[4] == debug_data_oe && debug_data_in == gpio_in[4])
      else $error("pin 4 not owned by debug");
   dbg_clock_a: assert property (!led_drive_actual |-> debug_clock_in == gpio_in[5])
      else $error("debug clock not from pin 5");
   // The pin 5 pull-down transistor is its open-drain low driver, so it shows as the output enable.
   led_pin_a: assert property (led_drive_actual |-> !debug_clock_in && !pad_drive.oe[5])
      else $error("pin 5 wrong while LED on");
   matrix_pull_a: assert property (pad_drive.pulldown_en[1] |->
      pad_drive.pulldown_en[3:1] == 3'h7 && pad_drive.pullup_en[3:1] == 3'h0)
      else $error("matrix pulls wrong");
   led_od_a: assert property (!pad_drive.pullup_en[5] && !pad_drive.out[5])
      else $error("pin 5 not open drain");
   led_session_a: assert property (debug_session |-> !led_drive_actual)
      else $error("LED lit during session");
   led_level_a: assert property (led_drive_actual |-> led_current_level != 2'h0)
      else $error("LED on with zero level");
endmodule
bind gpio_option_latch_and_role_select gpio_opt_props gpio_opt_props_i (.clk_sys, .rst, .read, .write,
   .readdata, .waitrequest, .gpio_in, .pad_drive, .prog_supply_active, .debug_transaction, .debug_session,
   .debug_data_oe, .debug_data_in, .debug_clock_in, .crystal_oscillator_input, .led_current_level,
   .led_drive_actual);
`default_nettype wire

// ===== pad_partner_model.sv
/*
 Buttons, LED and debug adapter on the pins.
 Assumes pad controls from the block and a tester that presses buttons.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_partner_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire gpio_opt_pkg::pad_drive_t pad_drive,
   input wire logic led_drive_actual,
   input wire logic [9:0] button_press,
   input wire logic pin0_level,
   input wire logic connect_req,
   output logic [9:0] gpio_in,
   output logic debug_session
);
   import gpio_opt_pkg::*;
   logic float_bit;
   logic [9:0] low_v;
   logic [9:0] high_v;
   // An undriven pin toggles, so a missing pull is never read as a lucky level.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) float_bit <= 1'b0;
      else float_bit <= ~float_bit;
   end
   // Buttons and pull-downs win over pull-ups; pin 0 follows its own source.
   always_comb begin
      low_v = button_press | (pad_drive.oe & ~pad_drive.out) | (pad_drive.pulldown_en & ~pad_drive.oe);
      high_v = (pad_drive.oe & pad_drive.out) | pad_drive.pullup_en | {10{float_bit}};
      gpio_in = ~low_v & high_v;
      gpio_in[0] = pin0_level;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) debug_session <= 1'b0;
      else debug_session <= connect_req && (debug_session || !led_drive_actual);
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
 Testbench for the pad option latch and role select block.
 Drives the register bus and side inputs; the partner model plays the pins.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import gpio_opt_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, rst_pad = 1'b1, read = 1'b0, write = 1'b0;
   logic [ADDR_W-1:0] address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic waitrequest, debug_data_in, debug_clock_in, ref_clock_out, crystal_oscillator_input;
   logic prog_supply_active = 1'b0, debug_transaction = 1'b0, debug_data_out = 1'b0, debug_data_oe = 1'b0;
   logic clock_output_src = 1'b0, pin0_level = 1'b1, connect_req = 1'b0, led_drive_actual, debug_session;
   logic [9:0] gpio_in, button_press = 10'h000;
   logic [1:0] led_current_level;
   pad_drive_t pad_drive;
   int mismatches = 0, checks_done = 0;
   gpio_option_latch_and_role_select gpio_option_latch_and_role_select_i (.clk_sys, .rst, .rst_pad, .address,
      .read, .write, .writedata, .readdata, .waitrequest, .gpio_in, .pad_drive, .prog_supply_active,
      .debug_transaction, .debug_session, .debug_data_out, .debug_data_oe, .debug_data_in, .debug_clock_in,
      .clock_output_src, .ref_clock_out, .crystal_oscillator_input, .led_current_level, .led_drive_actual);
   pad_partner_model pad_partner_model_i (.clk_sys, .rst, .pad_drive, .led_drive_actual, .button_press,
      .pin0_level, .connect_req, .gpio_in, .debug_session);
   // Free-running system clock.
   always #5 clk_sys = ~clk_sys;
   task automatic close_out;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus access; an idle edge follows so strobes never change twice in a step.
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {24'h0, d};
      @(posedge clk_sys);
      // Only the watchdog ends a wait that never completes.
      while (waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string what);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h0, e}, what);
   endtask
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rst_pad <= 1'b0;
      @(posedge clk_sys);
      rchk(PORT_CTRL_OFS, 8'h00, "ctrl");
      rchk(PORT_SET_OFS, 8'h00, "set");
      rchk(CRYSTAL_CTRL_OFS, 8'h00, "crystal ctrl");
      rchk(PORT_LOW_VALUE_OFS, 8'hDF, "low value");
      rchk(PORT_HIGH_VALUE_OFS, 8'h03, "high value");
      rchk(PORT_LOW_CFG_OFS, 8'h00, "low cfg");
      rchk(READBACK_OFS, 8'h00, "readback");
      chk(32'(pad_drive.pullup_en[3:1]), 32'h7, "pullups idle");
      // Matrix entry: pins 3..1 made open-drain inputs, then request and strobe.
      bus(1'b1, PORT_LOW_VALUE_OFS, 8'hDF);
      bus(1'b1, PORT_LOW_CFG_OFS, 8'h00);
      bus(1'b1, PORT_CTRL_OFS, 8'h40);
      rchk(PORT_CTRL_OFS, 8'h00, "pending");
      bus(1'b1, PORT_CTRL_OFS, 8'hC0);
      bus(1'b1, PORT_CTRL_OFS, 8'h40);
      rchk(PORT_CTRL_OFS, 8'h40, "matrix");
      chk(32'(pad_drive.pullup_en[3:1]), 32'h0, "matrix pullups");
      chk(32'(pad_drive.pulldown_en[3:1]), 32'h7, "matrix pulldowns");
      bus(1'b1, PORT_CTRL_OFS, 8'h00);
      rchk(PORT_CTRL_OFS, 8'h40, "held");
      // A core reset alone must not touch the store.
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rchk(PORT_CTRL_OFS, 8'h40, "retained");
      bus(1'b1, PORT_CTRL_OFS, 8'h20);
      bus(1'b1, PORT_CTRL_OFS, 8'hA0);
      bus(1'b1, PORT_CTRL_OFS, 8'h20);
      rchk(PORT_CTRL_OFS, 8'h20, "roff");
      chk(32'(pad_drive.pullup_en[3:1]), 32'h4, "roff pullups");
      chk(32'(pad_drive.pulldown_en[3:1]), 32'h0, "roff pulldowns");
      bus(1'b1, PORT_CTRL_OFS, 8'h80);
      bus(1'b1, PORT_CTRL_OFS, 8'h00);
      rchk(PORT_CTRL_OFS, 8'h00, "cleared");
      // Pin 0, pin 3 and clock output roles.
      bus(1'b1, CRYSTAL_CTRL_OFS, 8'h01);
      chk(32'(crystal_oscillator_input), 32'h1, "crystal input");
      prog_supply_active <= 1'b1;
      @(posedge clk_sys);
      chk(32'(crystal_oscillator_input), 32'h0, "crystal under supply");
      bus(1'b1, PORT_SET_OFS, 8'h01);
      chk(32'(ref_clock_out), 32'h1, "ref high");
      button_press <= 10'h008;
      @(posedge clk_sys);
      chk(32'(ref_clock_out), 32'h0, "ref low");
      button_press <= 10'h000;
      bus(1'b1, PORT_SET_OFS, 8'h0E);
      clock_output_src <= 1'b1;
      @(posedge clk_sys);
      chk(32'({pad_drive.out[6], pad_drive.out[4]}), 32'h3, "clock out");
      debug_transaction <= 1'b1;
      debug_data_oe <= 1'b1;
      @(posedge clk_sys);
      chk(32'({pad_drive.out[6], pad_drive.out[4]}), 32'h2, "debug data");
      debug_transaction <= 1'b0;
      // LED at every level, then the debug adapter.
      bus(1'b1, PORT_LOW_VALUE_OFS, 8'hFF);
      rchk(PORT_LOW_VALUE_OFS, 8'hDF, "led level zero");
      for (int lv = 1; lv < 4; lv++) begin
         bus(1'b1, PORT_CTRL_OFS, 8'(lv));
         chk(32'(led_current_level), 32'(lv), "level");
         rchk(READBACK_OFS, 8'h01, "led on");
      end
      chk(32'(pad_drive.oe[5]), 32'h0, "led pulldown");
      connect_req <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(32'(debug_session), 32'h0, "connect refused");
      bus(1'b1, PORT_LOW_VALUE_OFS, 8'hDF);
      // The adapter only sees the dark LED at the idle edge, so its session shows one edge later.
      @(posedge clk_sys);
      chk(32'(debug_session), 32'h1, "connected");
      chk(32'(pad_drive.oe[5]), 32'h1, "debug pulldown");
      bus(1'b1, PORT_LOW_VALUE_OFS, 8'hFF);
      rchk(READBACK_OFS, 8'h00, "led off");
      rchk(PORT_LOW_VALUE_OFS, 8'hFF, "intended");
      bus(1'b1, READBACK_OFS, 8'h01);
      rchk(READBACK_OFS, 8'h00, "read only");
      close_out();
   end
   // Watchdog well beyond the roughly 140 cycles the tests need.
   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
